// file: dnc_defines.svh
// Constants for the two-loop clock core: register offsets, field
// positions, reset values, limits and timing counts.
// Assumes a 40 MHz system clock and byte-wide register access.
`ifndef DNC_DEFINES_SVH
`define DNC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DNC_ADDR_SEL_A 8'hEC
`define DNC_ADDR_OFS_A 8'hED
`define DNC_ADDR_SEL_B 8'hF1
`define DNC_ADDR_OFS_B 8'hF2
`define DNC_OFS_BYTES 3'h4

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DNC_SEL_EN_BIT 7
`define DNC_SEL_ACT_BIT 6
`define DNC_SEL_RESET 8'h00
`define DNC_OFS_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Frequency word limits, nominal word is 2^29
// ----------------------------------------------------------------
`define DNC_NOM_FCW 32'h2000_0000
`define DNC_PULL_52 32'h0000_6D0D
`define DNC_PULL_130 32'h0001_10A1
`define DNC_PULL_400 32'h0003_46DC
`define DNC_PULL_3900 32'h001F_F2E4
`define DNC_SLOPE_61 32'h0000_7FED
`define DNC_SLOPE_7P5 32'h0000_0FBA
`define DNC_SLOPE_0P885 32'h0000_01DB
`define DNC_FINE_LIM 32'h0028_F5C2
`define DNC_FINE_SHIFT 3
`define DNC_BW_MAX 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DNC_CLK_MHZ 40
`define DNC_LOCK_QUAL_US 100
`define DNC_LOCK_QUAL_CYC (`DNC_LOCK_QUAL_US * `DNC_CLK_MHZ)
`define DNC_LOCK_TH 16'h0002

`endif

// file: dnc_pkg.sv
// Types shared by the two-loop clock core.
// Assumes nothing beyond a SystemVerilog elaborator.
package dnc_pkg;
  // Loop operating states
  typedef enum logic [1:0] {
    dnc_st_free,
    dnc_st_norm,
    dnc_st_hold
  } dnc_state_t;
endpackage : dnc_pkg

// file: dnc_core.sv
// Two digital loops, four oscillator sources, two synthesizers with
// stoppable, skewable output dividers and the oscillator slot registers.
// Assumes synchronous inputs, ref_edge as one-cycle pulses per reference.
`include "dnc_defines.svh"

module dnc_core
  import dnc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] ref_edge,
  input wire logic [3:0][3:0] ref_fail,
  input wire logic [1:0][1:0] ref_sel,
  input wire logic [1:0][3:0] auto_holdover_fail_mask,
  input wire logic [1:0] force_freerun,
  input wire logic [1:0] force_holdover,
  input wire logic [1:0] loop_nco_mode,
  input wire logic [1:0] phase_error_clear_mode,
  input wire logic [1:0][1:0] pull_in_sel,
  input wire logic [1:0][2:0] bw_sel,
  input wire logic [1:0][1:0] slope_sel,
  input wire logic [1:0][15:0] fwd_div,
  input wire logic [1:0][15:0] fb_div,
  input wire logic [1:0][1:0] synth_src,
  input wire logic [1:0][15:0] synth_m,
  input wire logic [1:0][15:0] synth_n,
  input wire logic [1:0][15:0] out_div,
  input wire logic [1:0][7:0] skew_coarse,
  input wire logic [1:0][3:0] skew_fine_in,
  input wire logic [1:0] stop_ser,
  input wire logic [1:0] stop_gpio,
  input wire logic [1:0] stop_on_fall,
  output logic [1:0][1:0] loop_state,
  output logic [1:0] loop_lock,
  output logic [1:0] loop_holdover,
  output logic [1:0] clk_out,
  output logic [1:0][3:0] skew_fine_out
);

  default clocking dnc_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] dnc_clamp(input logic signed [31:0] v, input logic signed [31:0] lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end else begin
      return v;
    end
  endfunction : dnc_clamp

  // ----------------------------------------------------------------
  // Oscillator slot registers
  // ----------------------------------------------------------------
  logic [7:0] sel_reg [2];
  logic [31:0] fine_reg [2];
  logic [1:0] src_a;
  logic [1:0] src_b;
  logic slot_a_act;
  logic slot_b_act;
  logic both_nco;
  logic [3:0] src_act;
  logic signed [31:0] src_ofs [4];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_reg[0] <= `DNC_SEL_RESET;
      sel_reg[1] <= `DNC_SEL_RESET;
      fine_reg[0] <= `DNC_OFS_RESET;
      fine_reg[1] <= `DNC_OFS_RESET;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `DNC_ADDR_SEL_A: sel_reg[0] <= reg_wdata;
        `DNC_ADDR_SEL_B: sel_reg[1] <= reg_wdata;
        `DNC_ADDR_OFS_A: fine_reg[0][31:24] <= reg_wdata;
        `DNC_ADDR_OFS_A + 8'h01: fine_reg[0][23:16] <= reg_wdata;
        `DNC_ADDR_OFS_A + 8'h02: fine_reg[0][15:8] <= reg_wdata;
        `DNC_ADDR_OFS_A + 8'h03: fine_reg[0][7:0] <= reg_wdata;
        `DNC_ADDR_OFS_B: fine_reg[1][31:24] <= reg_wdata;
        `DNC_ADDR_OFS_B + 8'h01: fine_reg[1][23:16] <= reg_wdata;
        `DNC_ADDR_OFS_B + 8'h02: fine_reg[1][15:8] <= reg_wdata;
        `DNC_ADDR_OFS_B + 8'h03: fine_reg[1][7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register read port, unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `DNC_ADDR_SEL_A: reg_rdata <= {sel_reg[0][7], slot_a_act, sel_reg[0][5:0]};
        `DNC_ADDR_SEL_B: reg_rdata <= {sel_reg[1][7], slot_b_act, sel_reg[1][5:0]};
        `DNC_ADDR_OFS_A: reg_rdata <= fine_reg[0][31:24];
        `DNC_ADDR_OFS_A + 8'h01: reg_rdata <= fine_reg[0][23:16];
        `DNC_ADDR_OFS_A + 8'h02: reg_rdata <= fine_reg[0][15:8];
        `DNC_ADDR_OFS_A + 8'h03: reg_rdata <= fine_reg[0][7:0];
        `DNC_ADDR_OFS_B: reg_rdata <= fine_reg[1][31:24];
        `DNC_ADDR_OFS_B + 8'h01: reg_rdata <= fine_reg[1][23:16];
        `DNC_ADDR_OFS_B + 8'h02: reg_rdata <= fine_reg[1][15:8];
        `DNC_ADDR_OFS_B + 8'h03: reg_rdata <= fine_reg[1][7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // dedicated pair unusable while both loops run as oscillators
  assign both_nco = &loop_nco_mode;
  assign src_a = sel_reg[0][1:0];
  assign src_b = sel_reg[1][1:0];
  assign slot_a_act = sel_reg[0][`DNC_SEL_EN_BIT] && (src_a[1] ? !both_nco : loop_nco_mode[src_a[0]]);
  // second slot yields when the active first slot points at the same source
  assign slot_b_act = sel_reg[1][`DNC_SEL_EN_BIT] && (src_b[1] ? !both_nco : loop_nco_mode[src_b[0]])
                      && !(slot_a_act && (src_a == src_b));

  // fine offset per source, scaled and held to half a percent
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      src_act[s] = 1'b0;
      src_ofs[s] = 32'sh0000_0000;
      if (slot_a_act && (src_a == 2'(s))) begin
        src_act[s] = 1'b1;
        src_ofs[s] = dnc_clamp($signed(fine_reg[0]) >>> `DNC_FINE_SHIFT, $signed(`DNC_FINE_LIM));
      end else if (slot_b_act && (src_b == 2'(s))) begin
        src_act[s] = 1'b1;
        src_ofs[s] = dnc_clamp($signed(fine_reg[1]) >>> `DNC_FINE_SHIFT, $signed(`DNC_FINE_LIM));
      end
    end
  end

  slot_pair_a: assert property (!(slot_a_act && slot_b_act && src_a == src_b))
    else $error("both slots drive one source");
  nco_pair_off_a: assert property (both_nco |-> !src_act[2] && !src_act[3])
    else $error("dedicated oscillator active with both loops as oscillators");

  // ----------------------------------------------------------------
  // Oscillator sources: two loops, two dedicated oscillators
  // ----------------------------------------------------------------
  logic signed [31:0] app_reg [2];
  logic [31:0] acc_reg [4];
  logic [3:0] tick_reg;
  logic [31:0] fcw [4];

  // Frequency words, an idle dedicated oscillator stands still
  assign fcw[0] = `DNC_NOM_FCW + app_reg[0];
  assign fcw[1] = `DNC_NOM_FCW + app_reg[1];
  assign fcw[2] = src_act[2] ? `DNC_NOM_FCW + src_ofs[2] : 32'h0000_0000;
  assign fcw[3] = src_act[3] ? `DNC_NOM_FCW + src_ofs[3] : 32'h0000_0000;

  // Phase accumulators, carry out is the source tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int s = 0; s < 4; s++) begin
        acc_reg[s] <= 32'h0000_0000;
      end
      tick_reg <= 4'h0;
    end else if (ce) begin
      for (int s = 0; s < 4; s++) begin
        {tick_reg[s], acc_reg[s]} <= {1'b0, acc_reg[s]} + {1'b0, fcw[s]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital loops
  // ----------------------------------------------------------------
  dnc_state_t state_reg [2];
  logic signed [31:0] freq_reg [2];
  logic signed [31:0] hold_reg [2];
  logic signed [15:0] pe_reg [2];
  logic [1:0] fail_um;
  logic [1:0] ref_ok;
  logic signed [31:0] pull_lim [2];
  logic signed [31:0] slope_lim [2];

  for (genvar g = 0; g < 2; g++) begin : g_loop
    logic [15:0] fwd_cnt_reg;
    logic [15:0] fb_cnt_reg;
    logic ref_tick_reg;
    logic fb_tick_reg;
    logic [1:0] sel_prev_reg;
    logic [11:0] lock_cnt_reg;
    logic [2:0] bw_eff;
    logic signed [31:0] step;

    always_comb begin
      case (pull_in_sel[g])
        2'h0: pull_lim[g] = $signed(`DNC_PULL_52);
        2'h1: pull_lim[g] = $signed(`DNC_PULL_130);
        2'h2: pull_lim[g] = $signed(`DNC_PULL_400);
        default: pull_lim[g] = $signed(`DNC_PULL_3900);
      endcase
    end

    // phase slope limit, top code reuses the 3900 pull-in limit
    always_comb begin
      case (slope_sel[g])
        2'h0: slope_lim[g] = $signed(`DNC_SLOPE_61);
        2'h1: slope_lim[g] = $signed(`DNC_SLOPE_7P5);
        2'h2: slope_lim[g] = $signed(`DNC_SLOPE_0P885);
        default: slope_lim[g] = $signed(`DNC_PULL_3900);
      endcase
    end

    // only unmasked failures of the active reference enter holdover; ref_ok counts every failure, masked or not
    assign fail_um[g] = |(ref_fail[ref_sel[g]] & ~auto_holdover_fail_mask[g]);
    assign ref_ok[g] = ~|ref_fail[ref_sel[g]];

    // divisors read live, cascade with synth
    // forward and feedback dividers on reference and source ticks
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        fwd_cnt_reg <= 16'h0000;
        fb_cnt_reg <= 16'h0000;
        ref_tick_reg <= 1'b0;
        fb_tick_reg <= 1'b0;
      end else if (ce) begin
        ref_tick_reg <= 1'b0;
        fb_tick_reg <= 1'b0;
        // one of four references feeds the loop
        if (ref_edge[ref_sel[g]]) begin
          if ({1'b0, fwd_cnt_reg} + 17'h0_0001 >= {1'b0, fwd_div[g]}) begin
            fwd_cnt_reg <= 16'h0000;
            ref_tick_reg <= 1'b1;
          end else begin
            fwd_cnt_reg <= fwd_cnt_reg + 16'h0001;
          end
        end
        if (tick_reg[g]) begin
          if ({1'b0, fb_cnt_reg} + 17'h0_0001 >= {1'b0, fb_div[g]}) begin
            fb_cnt_reg <= 16'h0000;
            fb_tick_reg <= 1'b1;
          end else begin
            fb_cnt_reg <= fb_cnt_reg + 16'h0001;
          end
        end
      end
    end

    // phase error, cleared on switch when clear mode is on
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pe_reg[g] <= 16'sh0000;
        sel_prev_reg <= 2'h0;
      end else if (ce) begin
        sel_prev_reg <= ref_sel[g];
        if (state_reg[g] != dnc_st_norm || (phase_error_clear_mode[g] && sel_prev_reg != ref_sel[g])) begin
          pe_reg[g] <= 16'sh0000;
        end else if (ref_tick_reg && !fb_tick_reg && pe_reg[g] != 16'sh7FFF) begin
          pe_reg[g] <= pe_reg[g] + 16'sh0001;
        end else if (fb_tick_reg && !ref_tick_reg && pe_reg[g] != -16'sh7FFF) begin
          pe_reg[g] <= pe_reg[g] - 16'sh0001;
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        state_reg[g] <= dnc_st_free;
      end else if (ce) begin
        case (state_reg[g])
          // stays free until a reference is usable
          dnc_st_free: begin
            if (!force_freerun[g] && !force_holdover[g] && ref_ok[g]) begin
              state_reg[g] <= dnc_st_norm;
            end
          end
          // unmasked failure or host request enters holdover
          dnc_st_norm: begin
            if (force_freerun[g]) begin
              state_reg[g] <= dnc_st_free;
            end else if (force_holdover[g] || fail_um[g]) begin
              state_reg[g] <= dnc_st_hold;
            end
          end
          // returns to normal once holdover is not forced and the active reference shows no failure
          dnc_st_hold: begin
            if (force_freerun[g]) begin
              state_reg[g] <= dnc_st_free;
            end else if (!force_holdover[g] && ref_ok[g]) begin
              state_reg[g] <= dnc_st_norm;
            end
          end
          default: state_reg[g] <= dnc_st_free;
        endcase
      end
    end

    // filter gain follows bandwidth live, top code saturates
    assign bw_eff = (bw_sel[g] > `DNC_BW_MAX) ? `DNC_BW_MAX : bw_sel[g];
    assign step = {{16{pe_reg[g][15]}}, pe_reg[g]} <<< bw_eff;

    // frequency integrated within the pull-in limit, stored while locked, replayed in holdover
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        freq_reg[g] <= 32'sh0000_0000;
        hold_reg[g] <= 32'sh0000_0000;
        app_reg[g] <= 32'sh0000_0000;
      end else if (ce) begin
        case (state_reg[g])
          dnc_st_norm: begin
            freq_reg[g] <= dnc_clamp(freq_reg[g] + step, pull_lim[g]);
            if (loop_lock[g]) begin
              hold_reg[g] <= freq_reg[g];
            end
          end
          dnc_st_hold: freq_reg[g] <= hold_reg[g];
          default: freq_reg[g] <= 32'sh0000_0000;
        endcase
        // oscillator mode replaces the loop output
        if (loop_nco_mode[g]) begin
          app_reg[g] <= src_act[g] ? src_ofs[g] : 32'sh0000_0000;
        end else if (state_reg[g] == dnc_st_norm) begin
          // output deviation bounded by the slope limit
          app_reg[g] <= hold_reg[g] + dnc_clamp(freq_reg[g] - hold_reg[g], slope_lim[g]);
        end else begin
          app_reg[g] <= freq_reg[g];
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        lock_cnt_reg <= 12'h000;
        loop_lock[g] <= 1'b0;
        loop_holdover[g] <= 1'b0;
        loop_state[g] <= 2'h0;
      end else if (ce) begin
        loop_state[g] <= state_reg[g];
        loop_holdover[g] <= (state_reg[g] == dnc_st_hold);
        if (state_reg[g] != dnc_st_norm || pe_reg[g] > $signed(`DNC_LOCK_TH) || pe_reg[g] < -$signed(`DNC_LOCK_TH)) begin
          lock_cnt_reg <= 12'h000;
          loop_lock[g] <= 1'b0;
        end else if (lock_cnt_reg == 12'(`DNC_LOCK_QUAL_CYC)) begin
          loop_lock[g] <= 1'b1;
        end else begin
          lock_cnt_reg <= lock_cnt_reg + 12'h001;
        end
      end
    end

    free_zero_a: assert property ((ce && state_reg[g] == dnc_st_free) |=> freq_reg[g] == 32'sh0000_0000)
      else $error("free-run frequency not at master rate");
    hold_store_a: assert property ((ce && state_reg[g] == dnc_st_norm && loop_lock[g])
      |=> hold_reg[g] == $past(freq_reg[g]))
      else $error("locked frequency not stored");
    hold_replay_a: assert property ((ce && state_reg[g] == dnc_st_hold) |=> freq_reg[g] == $past(hold_reg[g]))
      else $error("holdover not using stored frequency");
    pull_range_a: assert property ((ce && state_reg[g] == dnc_st_norm)
      |=> freq_reg[g] <= $past(pull_lim[g]) && freq_reg[g] >= -$past(pull_lim[g]))
      else $error("frequency outside pull-in range");
    fail_entry_a: assert property ((ce && state_reg[g] == dnc_st_norm && fail_um[g] && !force_freerun[g])
      |=> state_reg[g] == dnc_st_hold ##1 loop_holdover[g] || !$past(ce, 1))
      else $error("unmasked failure did not enter holdover");
    masked_stay_a: assert property ((ce && state_reg[g] == dnc_st_norm && !fail_um[g] && !force_freerun[g]
      && !force_holdover[g]) |=> state_reg[g] == dnc_st_norm)
      else $error("masked failure caused holdover");
    lock_state_a: assert property (loop_lock[g] |-> $past(state_reg[g]) == dnc_st_norm)
      else $error("lock shown outside normal state");
  end

  // ----------------------------------------------------------------
  // Synthesizers and output dividers
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 2; k++) begin : g_syn
    logic [16:0] macc_reg;
    logic stick_reg;
    logic [15:0] div_cnt_reg;
    logic [7:0] skew_prev_reg;
    logic [7:0] skew_cnt_reg;
    logic [16:0] macc_sum;
    logic stop_now;

    assign macc_sum = macc_reg + {1'b0, synth_m[k]};

    // source select, M over N fractional rate
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        macc_reg <= 17'h0_0000;
        stick_reg <= 1'b0;
      end else if (ce) begin
        stick_reg <= 1'b0;
        if (tick_reg[synth_src[k]] && synth_n[k] != 16'h0000) begin
          if (macc_sum >= {1'b0, synth_n[k]}) begin
            macc_reg <= macc_sum - {1'b0, synth_n[k]};
            stick_reg <= 1'b1;
          end else begin
            macc_reg <= macc_sum;
          end
        end
      end
    end

    // stop from either control at the chosen level
    assign stop_now = (stop_ser[k] || stop_gpio[k]) && (clk_out[k] == !stop_on_fall[k]);

    // toggle divider, each half period equal
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        div_cnt_reg <= 16'h0000;
        clk_out[k] <= 1'b0;
        skew_prev_reg <= 8'h00;
        skew_cnt_reg <= 8'h00;
        skew_fine_out[k] <= 4'h0;
      end else if (ce) begin
        skew_prev_reg <= skew_coarse[k];
        // fine step passed on, coarse step swallows ticks
        skew_fine_out[k] <= skew_fine_in[k];
        if (skew_prev_reg != skew_coarse[k]) begin
          skew_cnt_reg <= skew_coarse[k];
        end else if (stick_reg && skew_cnt_reg != 8'h00) begin
          skew_cnt_reg <= skew_cnt_reg - 8'h01;
        end else if (stick_reg && !stop_now) begin
          if ({1'b0, div_cnt_reg} + 17'h0_0001 >= {1'b0, out_div[k]}) begin
            div_cnt_reg <= 16'h0000;
            clk_out[k] <= !clk_out[k];
          end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
          end
        end
      end
    end

    stop_hold_a: assert property ((ce && $past(ce) && $past(stop_now)) |-> $stable(clk_out[k]))
      else $error("stopped output moved");
  end

endmodule : dnc_core

// file: dnc_ref_src.sv
// Model of the four reference clock sources facing the loop core.
// Assumes the bench clock; failure levels are requested by the bench.
module dnc_ref_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0][3:0] fail_req,
  output logic [3:0] ref_edge,
  output logic [3:0][3:0] ref_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_reg;
  // Free counter spaces the reference edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
  // edge rate far above loop bandwidth
  // no external feedback through references
  // One-cycle edge per reference, each at its own phase
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ref_edge[i] = (cnt_reg == 6'(i * 8));
    end
  end
  // Monitor flags follow the bench request
  assign ref_fail = fail_req;
endmodule : dnc_ref_src

// file: tb.sv
// Self-checking bench: slot registers, loop states, output stop and skew.
// Assumes dnc_core, dnc_pkg and the reference source model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] ref_edge;
  logic [3:0][3:0] ref_fail;
  logic [3:0][3:0] fail_req = 16'h0000;
  logic [1:0][1:0] ref_sel = 4'h4;
  logic [1:0][3:0] auto_holdover_fail_mask = 8'h01;
  logic [1:0] force_freerun = 2'h0;
  logic [1:0] force_holdover = 2'h0;
  logic [1:0] loop_nco_mode = 2'h0;
  logic [1:0] phase_error_clear_mode = 2'h3;
  logic [1:0][1:0] pull_in_sel = 4'hF;
  logic [1:0][2:0] bw_sel = 6'h12;
  logic [1:0][1:0] slope_sel = 4'hF;
  logic [1:0][1:0] synth_src = 4'h4;
  logic [1:0][7:0] skew_coarse = 16'h0000;
  logic [1:0][3:0] skew_fine_in = 8'h00;
  logic [1:0] stop_ser = 2'h0;
  logic [1:0] stop_gpio = 2'h0;
  logic [1:0] stop_on_fall = 2'h1;
  logic [1:0][1:0] loop_state;
  logic [1:0] loop_lock;
  logic [1:0] loop_holdover;
  logic [1:0] clk_out;
  logic [1:0][3:0] skew_fine_out;
  logic [23:0] slot_tab [6] = '{24'hEC_82C2, 24'hF1_8282, 24'hF1_83C3, 24'hEC_4000, 24'hEC_8080, 24'h10_FF00};
  int num_errors = 0;
  int samples_checked = 0;
  // Bench clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  dnc_ref_src u_src (.clk_sys, .rst, .fail_req, .ref_edge, .ref_fail);
  dnc_core DUT (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_edge, .ref_fail,
    .ref_sel, .auto_holdover_fail_mask, .force_freerun, .force_holdover, .loop_nco_mode, .phase_error_clear_mode,
    .pull_in_sel, .bw_sel, .slope_sel, .fwd_div(32'h0001_0001), .fb_div(32'h0008_0008), .synth_src,
    .synth_m(32'h0001_0001), .synth_n(32'h0001_0001), .out_div(32'h0001_0001), .skew_coarse, .skew_fine_in,
    .stop_ser, .stop_gpio, .stop_on_fall, .loop_state, .loop_lock, .loop_holdover, .clk_out, .skew_fine_out);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd_chk
  // Picks one status output by index
  function automatic logic [1:0] probe(input int s);
    case (s)
      0: probe = loop_state[0];
      1: probe = loop_state[1];
      2: probe = {1'b0, clk_out[0]};
      3: probe = {1'b0, loop_holdover[0]};
      4: probe = {1'b0, loop_lock[0]};
      default: probe = {1'b0, clk_out[1]};
    endcase
  endfunction : probe
  // Waits up to n cycles for a value, or with stay set demands it for n cycles
  task automatic watch(input int s, input logic [1:0] exp, input int n, input bit stay);
    int k;
    logic [1:0] v;
    k = 0;
    v = probe(s);
    while (k < n && (stay ? v === exp : v !== exp)) begin
      @(negedge clk_sys);
      v = probe(s);
      k++;
    end
    chk($sformatf("status %0d", s), {6'h00, exp}, {6'h00, v});
    if (v !== exp) begin
      finish_test();
    end
  endtask : watch
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    watch(0, 2'h0, 1, 1'b1);
    rd_chk(8'hEC, 8'h00);
    rd_chk(8'hF2, 8'h00);
    // Slot enables, status bit, yielding and an unmapped place
    foreach (slot_tab[i]) begin
      wr(slot_tab[i][23:16], slot_tab[i][15:8]);
      rd_chk(slot_tab[i][23:16], slot_tab[i][7:0]);
    end
    loop_nco_mode = 2'h3;
    rd_chk(8'hEC, 8'hC0);
    rd_chk(8'hF1, 8'h83);
    loop_nco_mode = 2'h0;
    // Fine offset bytes of both slots
    for (int i = 0; i < 8; i++) begin
      wr(8'(i < 4 ? 8'hED + i : 8'hEE + i), 8'h11 * 8'(i + 1));
      rd_chk(8'(i < 4 ? 8'hED + i : 8'hEE + i), 8'h11 * 8'(i + 1));
    end
    ce = 1'b0;
    wr(8'hED, 8'hFF);
    ce = 1'b1;
    rd_chk(8'hED, 8'h11);
    // Loop state machine
    watch(0, 2'h1, 40, 1'b0);
    watch(1, 2'h1, 40, 1'b0);
    watch(3, 2'h0, 4, 1'b0);
    // Feedback divides source ticks down to the reference edge rate
    watch(4, 2'h1, 4200, 1'b0);
    force_holdover[0] = 1'b1;
    watch(0, 2'h2, 8, 1'b0);
    watch(3, 2'h1, 4, 1'b0);
    watch(4, 2'h0, 4, 1'b0);
    for (int b = 0; b < 7; b++) begin
      bw_sel[0] = 3'(b);
      watch(0, 2'h2, 4, 1'b1);
    end
    force_holdover[0] = 1'b0;
    watch(0, 2'h1, 8, 1'b0);
    fail_req[0] = 4'h1;
    watch(0, 2'h1, 20, 1'b1);
    fail_req[0] = 4'h2;
    watch(0, 2'h2, 8, 1'b0);
    fail_req[0] = 4'h0;
    watch(0, 2'h1, 8, 1'b0);
    for (int m = 0; m < 4; m++) begin
      pull_in_sel[0] = 2'(m);
      slope_sel[0] = 2'(m);
      ref_sel[0] = 2'(m);
      watch(0, 2'h1, 20, 1'b1);
    end
    force_freerun[0] = 1'b1;
    watch(0, 2'h0, 8, 1'b0);
    watch(4, 2'h0, 1, 1'b1);
    force_freerun[0] = 1'b0;
    // Output skew and stop from both controls
    skew_fine_in = 8'h5A;
    skew_coarse = 16'h0304;
    repeat (3) @(negedge clk_sys);
    chk("skew_fine_out", 8'h5A, skew_fine_out);
    stop_ser[0] = 1'b1;
    stop_gpio[1] = 1'b1;
    watch(2, 2'h0, 200, 1'b0);
    watch(2, 2'h0, 100, 1'b1);
    watch(5, 2'h1, 200, 1'b0);
    watch(5, 2'h1, 100, 1'b1);
    stop_ser = 2'h0;
    stop_gpio = 2'h0;
    watch(2, 2'h1, 200, 1'b0);
    finish_test();
  end
endmodule : tb
